// ==== logic/digipot_reset_control.sv ====
// Reset, supply supervision and serial slave control of a quad digital potentiometer
// Operation
// - Ordinary serial commands are accepted only while chip select is low.
// - High-voltage commands are accepted only while chip select sits at elevated level.
// - Device is a serial slave; serial clock is an input driven by host.
// - Wiper code zero is zero scale, terminal B, for 7 and 8 bits.
// - Full scale, terminal A, is code 0x100 (8-bit) or 0x80 (7-bit).
// - Four independent volatile wiper registers, one per resistor network.
// - Serial data output returns register contents and shows the command error flag.
// - Reset pin low gives the same reset state as power-on or brown-out.
// - During pin reset, terminal control and wiper registers are forced to defaults.
// - During pin reset the serial interface is disabled and ignores all traffic.
// - Supply above power-on trip loads defaults, then enables digital operation.
// - Supply below brown-out trip disables the serial interface.
// - Recovery from brown-out repeats the power-on initialisation exactly.
// - Weak pull-ups enabled while supply is low or reset pin low.
// - Above the trip point volatile commands still execute, even below 2.7V.
// - Command cut by brown-out may leave its register contents undefined.
// - Wiper default is mid-scale: 80h for 8-bit, 40h for 7-bit.
// - Terminal control registers reset to 1FFh, all terminals connected.
// - Error persists until chip select goes high and is reasserted.
module digipot_reset_control
  import digipot_pkg::*;
#(
  parameter int WIPER_BITS = 8
) (
  // Clock and system reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Pins and supply detector, asynchronous
  input wire logic i_cs_n,
  input wire logic i_high_voltage_select_level,
  input wire logic i_sck,
  input wire logic i_sdi,
  input wire logic i_reset_pin_n,
  input wire logic i_supply_ok,
  // Serial data output
  output logic o_sdo,
  output logic o_sdo_oe,
  // Supervision status
  output logic o_pullup_en,
  output logic o_ready,
  output logic o_error,
  output logic o_cmd_done,
  output logic o_hv_cmd,
  // Register contents towards the resistor networks
  output logic [8:0] o_wiper0,
  output logic [8:0] o_wiper1,
  output logic [8:0] o_wiper2,
  output logic [8:0] o_wiper3,
  output logic [8:0] o_terminal_connect_ctrl0,
  output logic [8:0] o_terminal_connect_ctrl1
);

  localparam logic [8:0] FULL = (WIPER_BITS == 8) ? WIPER_FULL_8 : WIPER_FULL_7;
  localparam logic [8:0] MID = (WIPER_BITS == 8) ? WIPER_MID_8 : WIPER_MID_7;
  localparam logic [4:0] HDR_LAST = 5'(HDR_BITS - 1);
  localparam logic [4:0] FRAME_LAST = 5'(FRAME_BITS - 1);
  localparam logic [4:0] HDR_COUNT = 5'(HDR_BITS);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Order: cs_n, hv, sck, sdi, reset pin, supply ok
  logic [5:0] sync1_q, sync2_q;
  logic sck_prev_q, sel_prev_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sync1_q <= 6'h31;
      sync2_q <= 6'h31;
      sck_prev_q <= 1'b0;
      sel_prev_q <= 1'b0;
    end else begin
      sync1_q <= {i_supply_ok, i_reset_pin_n, i_sdi, i_sck, i_high_voltage_select_level,
                  i_cs_n};
      sync2_q <= sync1_q;
      sck_prev_q <= sync2_q[2];
      sel_prev_q <= ~sync2_q[0] | sync2_q[1];
    end
  end

  logic cs_n_s, hv_s, sck_s, sdi_s, pin_n_s, supply_s;
  assign cs_n_s = sync2_q[0];
  assign hv_s = sync2_q[1];
  assign sck_s = sync2_q[2];
  assign sdi_s = sync2_q[3];
  assign pin_n_s = sync2_q[4];
  assign supply_s = sync2_q[5];

  logic selected, sel_rise, sck_rise, sck_fall;
  assign selected = ~cs_n_s | hv_s;
  assign sel_rise = selected & ~sel_prev_q;
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;

  // ==========================================================================
  // Internal reset and supervision
  // ==========================================================================
  // Held in a flop so the register file and frame logic see one clean level
  logic rst_int_q, rst_int_d, pullup_q, pullup_d;

  always_comb begin
    rst_int_d = ~pin_n_s | ~supply_s;
    pullup_d = ~pin_n_s | ~supply_s;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rst_int_q <= 1'b1;
      pullup_q <= 1'b1;
    end else begin
      rst_int_q <= rst_int_d;
      pullup_q <= pullup_d;
    end
  end

  // ==========================================================================
  // Frame engine
  // ==========================================================================
  frame_state_t state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] shin_q, shin_d;
  logic [9:0] shout_q, shout_d;
  logic sdo_q, sdo_d, oe_q, oe_d, err_q, err_d, hv_q, hv_d;
  logic done_q, done_d, hvcmd_q, hvcmd_d;
  logic wr_en;
  logic [8:0] wr_data, rd_data;
  logic [3:0] addr, addr_q, addr_d;
  spi_cmd_t cmd, cmd_q, cmd_d;
  logic is_wiper, is_terminal_connect_ctrl, allowed;

  // Header bits move on as data shifts in, so decode a latched copy after the check
  assign addr = (state_q == ST_HEADER) ? shin_q[ADDR_MSB - 10:ADDR_LSB - 10] : addr_q;
  assign cmd = (state_q == ST_HEADER) ? spi_cmd_t'(shin_q[CMD_MSB - 10:CMD_LSB - 10]) : cmd_q;
  assign is_wiper = (addr == ADDR_WIPER0) | (addr == ADDR_WIPER1) | (addr == ADDR_WIPER2)
                    | (addr == ADDR_WIPER3);
  assign is_terminal_connect_ctrl = (addr == ADDR_TCON0) | (addr == ADDR_TCON1);
  // Increment and decrement are meaningless on terminal control
  assign allowed = is_wiper | (is_terminal_connect_ctrl & ((cmd == CMD_WRITE) | (cmd == CMD_READ)));

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shin_d = shin_q;
    shout_d = shout_q;
    sdo_d = sdo_q;
    oe_d = oe_q;
    err_d = err_q;
    hv_d = hv_q;
    addr_d = addr_q;
    cmd_d = cmd_q;
    done_d = 1'b0;
    hvcmd_d = 1'b0;
    wr_en = 1'b0;
    wr_data = 9'h000;
    if (rst_int_q) begin
      state_d = ST_IDLE;
      err_d = 1'b0;
      oe_d = 1'b0;
      sdo_d = 1'b1;
    end else if (!selected) begin
      // A frame cut short commits nothing
      state_d = ST_IDLE;
      oe_d = 1'b0;
      sdo_d = 1'b1;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (sel_rise) begin
            state_d = ST_HEADER;
            cnt_d = 5'h00;
            err_d = 1'b0;
            hv_d = hv_s;
            oe_d = 1'b1;
            sdo_d = 1'b1;
          end
        end
        ST_HEADER: begin
          sdo_d = ~err_q;
          if (sck_rise) begin
            shin_d = {shin_q[14:0], sdi_s};
            cnt_d = cnt_q + 5'h01;
          end else if (cnt_q == HDR_COUNT) begin
            addr_d = addr;
            cmd_d = cmd;
            if (allowed) begin
              state_d = ST_DATA;
            end else begin
              err_d = 1'b1;
              state_d = ST_HOLD;
            end
          end
        end
        ST_DATA: begin
          if (sck_fall && cnt_q == HDR_COUNT) begin
            sdo_d = 1'b0;
            shout_d = {rd_data, 1'b0};
          end else if (sck_fall) begin
            sdo_d = shout_q[9];
            shout_d = {shout_q[8:0], 1'b0};
          end
          if (sck_rise) begin
            shin_d = {shin_q[14:0], sdi_s};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == FRAME_LAST) begin
              state_d = ST_HOLD;
              done_d = 1'b1;
              hvcmd_d = hv_q;
            end
          end
        end
        ST_HOLD: begin
          sdo_d = ~err_q;
          // Execute once, on the cycle after the last bit was taken
          if (done_q) begin
            unique case (cmd)
              CMD_WRITE: begin
                wr_en = 1'b1;
                wr_data = (is_wiper && shin_q[8:0] > FULL) ? FULL : shin_q[8:0];
              end
              CMD_INC: begin
                wr_en = 1'b1;
                wr_data = (rd_data >= FULL) ? FULL : rd_data + 9'h001;
              end
              CMD_DEC: begin
                wr_en = 1'b1;
                wr_data = (rd_data == WIPER_ZERO) ? WIPER_ZERO : rd_data - 9'h001;
              end
              CMD_READ: ;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
      shin_q <= 16'h0000;
      shout_q <= 10'h000;
      sdo_q <= 1'b1;
      oe_q <= 1'b0;
      err_q <= 1'b0;
      hv_q <= 1'b0;
      done_q <= 1'b0;
      hvcmd_q <= 1'b0;
      addr_q <= 4'h0;
      cmd_q <= CMD_WRITE;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shin_q <= shin_d;
      shout_q <= shout_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
      err_q <= err_d;
      hv_q <= hv_d;
      done_q <= done_d;
      hvcmd_q <= hvcmd_d;
      addr_q <= addr_d;
      cmd_q <= cmd_d;
    end
  end

  // ==========================================================================
  // Register storage
  // ==========================================================================
  digipot_regfile #(
    .WIPER_BITS(WIPER_BITS)
  ) u_regs (
    .i_clk(i_clk),
    .i_reset(rst_int_q | i_reset),
    .i_wr_en(wr_en),
    .i_wr_addr(addr),
    .i_wr_data(wr_data),
    .i_rd_addr(addr),
    .o_rd_data(rd_data),
    .o_wiper0(o_wiper0),
    .o_wiper1(o_wiper1),
    .o_wiper2(o_wiper2),
    .o_wiper3(o_wiper3),
    .o_tcon0(o_terminal_connect_ctrl0),
    .o_tcon1(o_terminal_connect_ctrl1)
  );

  assign o_sdo = sdo_q;
  assign o_sdo_oe = oe_q;
  assign o_pullup_en = pullup_q;
  assign o_ready = ~rst_int_q;
  assign o_error = err_q;
  assign o_cmd_done = done_q;
  assign o_hv_cmd = hvcmd_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_rst_wiper_mid;
    @(posedge i_clk) disable iff (i_reset)
      rst_int_q |=> (o_wiper0 == MID) && (o_wiper3 == MID);
  endproperty
  a_rst_wiper_mid: assert property (p_rst_wiper_mid)
    else $error("wiper not at mid-scale after reset");

  property p_rst_terminal_connect_ctrl;
    @(posedge i_clk) disable iff (i_reset)
      rst_int_q |=> (o_terminal_connect_ctrl0 == TERMINAL_CONNECT_CTRL_RESET)
                    && (o_terminal_connect_ctrl1 == TERMINAL_CONNECT_CTRL_RESET);
  endproperty
  a_rst_terminal_connect_ctrl: assert property (p_rst_terminal_connect_ctrl)
    else $error("terminal control not at default after reset");

  property p_rst_source;
    @(posedge i_clk) disable iff (i_reset)
      (!pin_n_s || !supply_s) |=> rst_int_q ##0 o_pullup_en;
  endproperty
  a_rst_source: assert property (p_rst_source)
    else $error("internal reset or pull-up missing");

  property p_no_write_in_reset;
    @(posedge i_clk) disable iff (i_reset)
      rst_int_q |-> !wr_en ##1 (state_q == ST_IDLE) && !o_sdo_oe;
  endproperty
  a_no_write_in_reset: assert property (p_no_write_in_reset)
    else $error("serial activity during reset");

  property p_full_scale;
    @(posedge i_clk) disable iff (i_reset)
      (o_wiper0 <= FULL) && (o_wiper1 <= FULL) && (o_wiper2 <= FULL) && (o_wiper3 <= FULL);
  endproperty
  a_full_scale: assert property (p_full_scale)
    else $error("wiper beyond full scale");

  property p_err_sticky;
    @(posedge i_clk) disable iff (i_reset)
      (err_q && selected && !sel_rise && !rst_int_q) |=> err_q;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error cleared without deselect");

  property p_dec_floor;
    @(posedge i_clk) disable iff (i_reset)
      (wr_en && cmd == CMD_DEC && rd_data == WIPER_ZERO) |-> wr_data == WIPER_ZERO;
  endproperty
  a_dec_floor: assert property (p_dec_floor)
    else $error("decrement below zero scale");

  property p_start_needs_select;
    @(posedge i_clk) disable iff (i_reset)
      (state_q == ST_IDLE && !selected) |=> (state_q == ST_IDLE);
  endproperty
  a_start_needs_select: assert property (p_start_needs_select)
    else $error("frame started without chip select");

  property p_error_on_sdo;
    @(posedge i_clk) disable iff (i_reset)
      (state_q == ST_HOLD && err_q && selected && !rst_int_q) |=> !o_sdo ##1 (!o_sdo || !o_sdo_oe);
  endproperty
  a_error_on_sdo: assert property (p_error_on_sdo)
    else $error("error not visible on serial output");

endmodule // digipot_reset_control

// ==== logic/digipot_pkg.sv ====
// Shared constants and types for the quad potentiometer reset and serial control logic
package digipot_pkg;

  // ==========================================================================
  // Serial frame layout
  // ==========================================================================
  localparam int FRAME_BITS = 16;
  localparam int HDR_BITS = 6;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 12;
  localparam int CMD_MSB = 11;
  localparam int CMD_LSB = 10;
  localparam int DATA_BITS = 10;

  // ==========================================================================
  // Register addresses
  // ==========================================================================
  localparam logic [3:0] ADDR_WIPER0 = 4'h0;
  localparam logic [3:0] ADDR_WIPER1 = 4'h1;
  localparam logic [3:0] ADDR_TCON0 = 4'h4;
  localparam logic [3:0] ADDR_WIPER2 = 4'h6;
  localparam logic [3:0] ADDR_WIPER3 = 4'h7;
  localparam logic [3:0] ADDR_TCON1 = 4'hA;

  // ==========================================================================
  // Codes and reset values
  // ==========================================================================
  localparam logic [8:0] WIPER_ZERO = 9'h000;
  localparam logic [8:0] WIPER_MID_8 = 9'h080;
  localparam logic [8:0] WIPER_MID_7 = 9'h040;
  localparam logic [8:0] WIPER_FULL_8 = 9'h100;
  localparam logic [8:0] WIPER_FULL_7 = 9'h080;
  localparam logic [8:0] TERMINAL_CONNECT_CTRL_RESET = 9'h1FF;
  localparam logic [8:0] TERMINAL_CONNECT_CTRL_FORCED = 9'h100;

  typedef enum logic [1:0] {
    CMD_WRITE = 2'b00,
    CMD_INC = 2'b01,
    CMD_DEC = 2'b10,
    CMD_READ = 2'b11
  } spi_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HEADER = 2'b01,
    ST_DATA = 2'b10,
    ST_HOLD = 2'b11
  } frame_state_t;

endpackage

// ==== logic/digipot_regfile.sv ====
// Volatile wiper and terminal control storage with registered read port
module digipot_regfile
  import digipot_pkg::*;
#(
  parameter int WIPER_BITS = 8
) (
  // Clock and internal reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Write port
  input wire logic i_wr_en,
  input wire logic [3:0] i_wr_addr,
  input wire logic [8:0] i_wr_data,
  // Read port
  input wire logic [3:0] i_rd_addr,
  output logic [8:0] o_rd_data,
  // Register contents
  output logic [8:0] o_wiper0,
  output logic [8:0] o_wiper1,
  output logic [8:0] o_wiper2,
  output logic [8:0] o_wiper3,
  output logic [8:0] o_tcon0,
  output logic [8:0] o_tcon1
);

  localparam logic [8:0] MID = (WIPER_BITS == 8) ? WIPER_MID_8 : WIPER_MID_7;

  logic [8:0] wiper_q [4];
  logic [8:0] wiper_d [4];
  logic [8:0] tcon0_q, tcon0_d, tcon1_q, tcon1_d, rd_q, rd_d;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wiper_d[i] = wiper_q[i];
    end
    tcon0_d = tcon0_q;
    tcon1_d = tcon1_q;
    if (i_wr_en) begin
      unique case (i_wr_addr)
        ADDR_WIPER0: wiper_d[0] = i_wr_data;
        ADDR_WIPER1: wiper_d[1] = i_wr_data;
        ADDR_WIPER2: wiper_d[2] = i_wr_data;
        ADDR_WIPER3: wiper_d[3] = i_wr_data;
        ADDR_TCON0: tcon0_d = i_wr_data | TERMINAL_CONNECT_CTRL_FORCED;
        ADDR_TCON1: tcon1_d = i_wr_data | TERMINAL_CONNECT_CTRL_FORCED;
        default: ;
      endcase
    end
    unique case (i_rd_addr)
      ADDR_WIPER0: rd_d = wiper_q[0];
      ADDR_WIPER1: rd_d = wiper_q[1];
      ADDR_WIPER2: rd_d = wiper_q[2];
      ADDR_WIPER3: rd_d = wiper_q[3];
      ADDR_TCON0: rd_d = tcon0_q;
      ADDR_TCON1: rd_d = tcon1_q;
      default: rd_d = 9'h000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int i = 0; i < 4; i++) begin
        wiper_q[i] <= MID;
      end
      tcon0_q <= TERMINAL_CONNECT_CTRL_RESET;
      tcon1_q <= TERMINAL_CONNECT_CTRL_RESET;
      rd_q <= 9'h000;
    end else begin
      for (int i = 0; i < 4; i++) begin
        wiper_q[i] <= wiper_d[i];
      end
      tcon0_q <= tcon0_d;
      tcon1_q <= tcon1_d;
      rd_q <= rd_d;
    end
  end

  assign o_rd_data = rd_q;
  assign o_wiper0 = wiper_q[0];
  assign o_wiper1 = wiper_q[1];
  assign o_wiper2 = wiper_q[2];
  assign o_wiper3 = wiper_q[3];
  assign o_tcon0 = tcon0_q;
  assign o_tcon1 = tcon1_q;

endmodule // digipot_regfile

// ==== tb/digipot_host_model.sv ====
// Host controller model acting as the serial master of the potentiometer
module digipot_host_model
  import digipot_pkg::*;
(
  // Clock and returned data
  input wire logic i_clk,
  input wire logic i_sdo,
  // Serial master pins
  output logic o_cs_n,
  output logic o_high_voltage_select_level,
  output logic o_sck,
  output logic o_sdi
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Captured serial output, one entry per bit
  // ==========================================================================
  logic [15:0] rx_q;

  initial begin
    o_cs_n = 1'b1;
    o_high_voltage_select_level = 1'b0;
    o_sck = 1'b0;
    o_sdi = 1'b1;
    rx_q = 16'h0000;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Each phase lasts 6 clocks, above the 4 the slave needs to sample
  task automatic frame(input logic [3:0] addr, input logic [1:0] cmd,
                       input logic [9:0] data, input logic hv, input int nbits);
    logic [15:0] word;
    word = {addr, cmd, data};
    @(posedge i_clk);
    if (hv) begin
      o_high_voltage_select_level <= 1'b1;
    end else begin
      o_cs_n <= 1'b0;
    end
    wait_clk(6);
    for (int i = 15; i >= 16 - nbits; i--) begin
      o_sdi <= word[i];
      wait_clk(6);
      rx_q[i] = i_sdo;
      o_sck <= 1'b1;
      wait_clk(6);
      o_sck <= 1'b0;
    end
    wait_clk(8);
    // Deselect between frames, and the data line no longer holds its value
    o_cs_n <= 1'b1;
    o_high_voltage_select_level <= 1'b0;
    o_sdi <= ~o_sdi;
    wait_clk(6);
  endtask
endmodule // digipot_host_model

// ==== tb/tb_digipot_reset_control.sv ====
// Self-checking testbench of the potentiometer reset and serial control
module tb_digipot_reset_control
  import digipot_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Signals
  // ==========================================================================
  logic i_clk, i_reset, i_reset_pin_n, i_supply_ok;
  logic cs_n, hv_sel, sck, sdi;
  logic o_sdo, o_sdo_oe, o_pullup_en, o_ready, o_error, o_cmd_done, o_hv_cmd;
  logic [8:0] o_wiper0, o_wiper1, o_wiper2, o_wiper3, o_tcon0, o_tcon1;
  int n_fail = 0;
  int tests_run = 0;
  int n_done = 0;
  int n_hv = 0;
  int cycles = 0;
  localparam logic [3:0] WADDR [4] = '{ADDR_WIPER0, ADDR_WIPER1, ADDR_WIPER2, ADDR_WIPER3};

  digipot_reset_control #(.WIPER_BITS(8)) DUT (
    .i_clk(i_clk), .i_reset(i_reset), .i_cs_n(cs_n),
    .i_high_voltage_select_level(hv_sel), .i_sck(sck), .i_sdi(sdi),
    .i_reset_pin_n(i_reset_pin_n), .i_supply_ok(i_supply_ok),
    .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_pullup_en(o_pullup_en), .o_ready(o_ready),
    .o_error(o_error), .o_cmd_done(o_cmd_done), .o_hv_cmd(o_hv_cmd),
    .o_wiper0(o_wiper0), .o_wiper1(o_wiper1), .o_wiper2(o_wiper2), .o_wiper3(o_wiper3),
    .o_terminal_connect_ctrl0(o_tcon0), .o_terminal_connect_ctrl1(o_tcon1)
  );

  digipot_host_model host (
    .i_clk(i_clk), .i_sdo(o_sdo), .o_cs_n(cs_n),
    .o_high_voltage_select_level(hv_sel), .o_sck(sck), .o_sdi(sdi)
  );

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // Pulse counters and hang guard, sized for about 6600 cycles of traffic
  always @(posedge i_clk) begin
    if (o_cmd_done === 1'b1) n_done++;
    if (o_hv_cmd === 1'b1) n_hv++;
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      finish_test();
    end
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [8:0] wip(input int k);
    case (k)
      0: wip = o_wiper0;
      1: wip = o_wiper1;
      2: wip = o_wiper2;
      default: wip = o_wiper3;
    endcase
  endfunction

  task automatic wait_ready(input int limit);
    for (int i = 0; i < limit && o_ready !== 1'b1; i++) @(posedge i_clk);
    check({8'h00, o_ready}, 9'h001, "ready after release");
  endtask

  task automatic chk_defaults();
    for (int k = 0; k < 4; k++) check(wip(k), WIPER_MID_8, "wiper default");
    check(o_tcon0, TERMINAL_CONNECT_CTRL_RESET, "tcon0 default");
    check(o_tcon1, TERMINAL_CONNECT_CTRL_RESET, "tcon1 default");
  endtask

  task automatic wr(input logic [3:0] a, input logic [1:0] c, input logic [8:0] d);
    host.frame(a, c, {1'b0, d}, 1'b0, 16);
  endtask

  task automatic rd(input logic [3:0] a, input logic [8:0] exp);
    host.frame(a, CMD_READ, 10'h000, 1'b0, 16);
    check(host.rx_q[8:0], exp, "read back");
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_defaults();
    chk_defaults();
    check({8'h00, o_pullup_en}, 9'h000, "pullups off when running");
    check({7'h00, o_error, o_sdo_oe}, 9'h000, "no error, sdo released");
  endtask

  task automatic t_write_read();
    logic [8:0] v [4];
    int d0;
    v = '{9'h000, 9'h05A, 9'h0FF, 9'h100};
    d0 = n_done;
    for (int k = 0; k < 4; k++) wr(WADDR[k], CMD_WRITE, v[k]);
    check(9'(n_done - d0), 9'h004, "one done pulse per frame");
    for (int k = 0; k < 4; k++) check(wip(k), v[k], "independent wiper");
    check(o_wiper0, WIPER_ZERO, "zero scale code");
    for (int k = 0; k < 4; k++) rd(WADDR[k], v[k]);
    wr(ADDR_WIPER1, CMD_WRITE, 9'h1FF);
    check(o_wiper1, WIPER_FULL_8, "write clamps at full scale");
    wr(ADDR_TCON0, CMD_WRITE, 9'h0A5);
    check(o_tcon0, 9'h1A5, "terminal_connect_ctrl write, top bit held");
    rd(ADDR_TCON0, 9'h1A5);
  endtask

  task automatic t_inc_dec();
    wr(ADDR_WIPER3, CMD_INC, 9'h000);
    check(o_wiper3, WIPER_FULL_8, "inc saturates at full");
    wr(ADDR_WIPER0, CMD_DEC, 9'h000);
    check(o_wiper0, WIPER_ZERO, "dec saturates at zero");
    wr(ADDR_WIPER0, CMD_INC, 9'h000);
    check(o_wiper0, 9'h001, "inc steps by one");
    wr(ADDR_WIPER3, CMD_DEC, 9'h000);
    check(o_wiper3, 9'h0FF, "dec steps by one");
  endtask

  task automatic t_error();
    logic [3:0] bad [3];
    bad = '{4'h2, 4'hB, 4'hF};
    wr(ADDR_TCON1, CMD_INC, 9'h000);
    check({8'h00, o_error}, 9'h001, "inc on terminal_connect_ctrl flags error");
    check(o_tcon1, TERMINAL_CONNECT_CTRL_RESET, "refused command leaves terminal_connect_ctrl");
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_WIPER2, CMD_WRITE, 9'h033);
      check({8'h00, o_error}, 9'h000, "reselect clears error");
      wr(bad[k], CMD_WRITE, 9'h011);
      check({8'h00, o_error}, 9'h001, "reserved address flags error");
    end
    rd(ADDR_WIPER2, 9'h033);
    check({8'h00, o_error}, 9'h000, "read after reselect clean");
  endtask

  task automatic t_abort_hv();
    int d0;
    int h0;
    d0 = n_done;
    h0 = n_hv;
    host.frame(ADDR_WIPER2, CMD_WRITE, 10'h077, 1'b0, 8);
    check(o_wiper2, 9'h033, "cut frame writes nothing");
    host.frame(ADDR_WIPER2, CMD_WRITE, 10'h066, 1'b1, 16);
    check(o_wiper2, 9'h066, "elevated select write");
    check(9'(n_hv - h0), 9'h001, "elevated select flagged");
    check(9'(n_done - d0), 9'h001, "only the whole frame completes");
  endtask

  // Holds the device in reset by pin, by supply, then by both
  task automatic t_reset_src(input int src);
    int d0;
    @(posedge i_clk);
    if (src != 1) i_reset_pin_n <= 1'b0;
    if (src != 0) i_supply_ok <= 1'b0;
    repeat (6) @(posedge i_clk);
    check({7'h00, o_ready, o_pullup_en}, 9'h001, "reset held, pullups on");
    chk_defaults();
    d0 = n_done;
    wr(ADDR_WIPER1, CMD_WRITE, 9'h0C3);
    check(9'(n_done - d0), 9'h000, "traffic in reset ignored");
    if (src == 2) begin
      i_reset_pin_n <= 1'b1;
      repeat (10) @(posedge i_clk);
      check({8'h00, o_ready}, 9'h000, "one source still holds reset");
    end
    i_reset_pin_n <= 1'b1;
    i_supply_ok <= 1'b1;
    @(posedge i_clk);
    check({8'h00, o_ready}, 9'h000, "ready not at once");
    wait_ready(10);
    chk_defaults();
    check({8'h00, o_pullup_en}, 9'h000, "pullups off again");
    wr(ADDR_WIPER1, CMD_WRITE, 9'h0C3);
    check(o_wiper1, 9'h0C3, "serial port back in use");
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    i_reset = 1'b1;
    i_reset_pin_n = 1'b1;
    i_supply_ok = 1'b1;
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    wait_ready(20);
    t_defaults();
    t_write_read();
    t_inc_dec();
    t_error();
    t_abort_hv();
    t_reset_src(0);
    t_reset_src(1);
    t_reset_src(2);
    finish_test();
  end
endmodule // tb_digipot_reset_control
